// ===== hw/temp_readout_defines.svh
// offsets, field positions, reset values and limits for the temperature readout
`ifndef TEMP_READOUT_DEFINES_SVH
`define TEMP_READOUT_DEFINES_SVH
`define CMD_LOCAL_RESULT 8'h00
`define CMD_REMOTE_RESULT 8'h01
`define CMD_TEMP_OFFSET 8'he0
`define CMD_OFFSET_HIGH 8'he1
`define LEN_SINGLE 8'h02
`define LEN_ALL_TEMPS 8'h04
`define DIODE_FAULT_CODE 16'h8000
`define OFFSET_RESET 16'h0000
`define RESULT_RESET 16'h0000
`define OFFSET_FRAC_LSBS 4
`define OFFSET_MAX 16'h2000
`define OFFSET_MIN 16'he000
`define TEMP_MAX 16'h7fff
`define TEMP_MIN 16'h8001
`endif

// ===== hw/temp_readout_pkg.sv
// types shared by the temperature readout modules
package temp_readout_pkg;
	typedef logic [15:0] temp_word_t;
	typedef logic [7:0] cmd_code_t;
	typedef enum logic [2:0]
	{
		RD_IDLE = 3'b001,
		RD_LOW = 3'b010,
		RD_HIGH = 3'b100
	} rd_state_t;
endpackage

// ===== hw/offset_add_if.sv
// carrier between the readout top and the offset adder
`timescale 1ns/1ps
interface offset_add_if;
	logic [15:0] raw;
	logic [15:0] offset;
	logic [15:0] sum;
	modport top (output raw, output offset, input sum);
	modport adder (input raw, input offset, output sum);
endinterface

// ===== hw/offset_adder.sv
// saturating signed add of the stored offset to a raw measurement
`timescale 1ns/1ps
`include "temp_readout_defines.svh"
module offset_adder
	import temp_readout_pkg::*;
(
	offset_add_if.adder port_a
);
	wire signed [16:0] wide_sum;
	wire over_pos;
	wire over_neg;

	// 17-bit sum so an overflow can clamp instead of wrapping
	assign wide_sum = $signed({port_a.raw[15], port_a.raw}) + $signed({port_a.offset[15], port_a.offset});
	assign over_pos = (wide_sum[16:15] == 2'b01);
	assign over_neg = (wide_sum[16:15] == 2'b10);
	// 0x8000 is the fault code, so the negative clamp stops one short
	assign port_a.sum = over_pos ? `TEMP_MAX :
		(over_neg || wide_sum[15:0] == `DIODE_FAULT_CODE) ? `TEMP_MIN : wide_sum[15:0];
endmodule

// ===== hw/temp_readout.sv
// temperature result and offset register file behind the serial command port
// Contract
// - command 0x00 returns local, 0x01 remote; two bytes, low byte first.
// - combined read at 0x00 returns local low, local high, remote low, remote high.
// - results are signed 16-bit two's complement spanning plus and minus 512 degrees.
// - one result lsb weighs one sixty-fourth degree; plus one is 0x0040.
// - open or shorted remote diode reports 0x8000 instead of a value.
// - offset setting lives at command 0xe0, host writes it after calibration.
// - stored offset is added to each measurement before it becomes readable.
// - offset uses result format, limited to 128 degrees, quarter degree steps.
// - offset written and read back low byte first, then high byte.
// - only 0xe0 is writable; writes to result locations change nothing.
`timescale 1ns/1ps
`include "temp_readout_defines.svh"
module temp_readout
	import temp_readout_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic local_done,
	input wire logic [15:0] local_raw,
	input wire logic remote_done,
	input wire logic [15:0] remote_raw,
	input wire logic remote_diode_fault,
	input wire logic cmd_start,
	input wire logic [7:0] cmd_code,
	input wire logic [7:0] cmd_read_len,
	input wire logic wr_valid,
	input wire logic [7:0] wr_data,
	input wire logic rd_req,
	output logic rd_valid,
	output logic [7:0] rd_data,
	output logic cmd_write_ok
);
	temp_word_t local_reg;
	temp_word_t local_next;
	temp_word_t remote_reg;
	temp_word_t remote_next;
	temp_word_t offset_reg;
	temp_word_t offset_next;
	temp_word_t snap_reg;
	temp_word_t snap_next;
	cmd_code_t code_reg;
	logic [7:0] len_reg;
	logic [1:0] byte_idx_reg;
	logic [7:0] wr_low_reg;
	logic wr_half_reg;
	logic [7:0] rd_data_next;
	logic rd_valid_reg;
	logic [15:0] offset_clamped;
	offset_add_if local_add ();
	offset_add_if remote_add ();

	offset_adder local_adder (.port_a(local_add.adder));
	offset_adder remote_adder (.port_a(remote_add.adder));

	// quarter-degree granularity: lower four of six fraction bits dropped
	wire [15:0] offset_grain = {wr_data, wr_low_reg} & ~16'h000f;
	wire offset_too_high = !offset_grain[15] && (offset_grain > `OFFSET_MAX);
	wire offset_too_low = offset_grain[15] && (offset_grain < `OFFSET_MIN);
	wire code_is_offset = (code_reg == `CMD_TEMP_OFFSET);
	wire code_is_local = (code_reg == `CMD_LOCAL_RESULT);
	wire code_is_remote = (code_reg == `CMD_REMOTE_RESULT);
	wire all_temps = code_is_local && (len_reg == `LEN_ALL_TEMPS);
	wire offset_commit = wr_valid && code_is_offset && wr_half_reg;

	assign local_add.raw = local_raw;
	assign local_add.offset = offset_reg;
	assign remote_add.raw = remote_raw;
	assign remote_add.offset = offset_reg;

	assign offset_clamped = offset_too_high ? `OFFSET_MAX :
		offset_too_low ? `OFFSET_MIN : offset_grain;
	assign offset_next = offset_commit ? offset_clamped : offset_reg;
	// results are signed 1/64 degree words; adder keeps them in that format
	assign local_next = local_done ? local_add.sum : local_reg;
	assign remote_next = !remote_done ? remote_reg :
		remote_diode_fault ? `DIODE_FAULT_CODE : remote_add.sum;

	// snapshot taken at each channel's low byte so a mid-read conversion cannot tear it
	wire [15:0] chan_word = (code_is_remote || byte_idx_reg[1]) ? remote_reg :
		code_is_offset ? offset_reg : code_is_local ? local_reg : 16'h0000;
	assign snap_next = (rd_req && !byte_idx_reg[0]) ? chan_word : snap_reg;
	// low byte from the live word, high byte from the snapshot
	assign rd_data_next = !byte_idx_reg[0] ? chan_word[7:0] : snap_reg[15:8];
	assign rd_valid = rd_valid_reg;
	assign cmd_write_ok = code_is_offset;

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			local_reg <= `RESULT_RESET;
			remote_reg <= `RESULT_RESET;
			offset_reg <= `OFFSET_RESET;
		end
		else
		begin
			local_reg <= local_next;
			remote_reg <= remote_next;
			offset_reg <= offset_next;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			code_reg <= 8'h00;
			len_reg <= `LEN_SINGLE;
			byte_idx_reg <= 2'h0;
			wr_half_reg <= 1'b0;
			wr_low_reg <= 8'h00;
		end
		else if (cmd_start)
		begin
			code_reg <= cmd_code;
			len_reg <= cmd_read_len;
			byte_idx_reg <= 2'h0;
			wr_half_reg <= 1'b0;
		end
		else
		begin
			if (rd_req)
				byte_idx_reg <= (all_temps || byte_idx_reg != 2'h1) ? byte_idx_reg + 2'h1 : 2'h0;
			if (wr_valid)
			begin
				wr_low_reg <= wr_data;
				wr_half_reg <= !wr_half_reg;
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			snap_reg <= `RESULT_RESET;
			rd_data <= 8'h00;
			rd_valid_reg <= 1'b0;
		end
		else
		begin
			snap_reg <= snap_next;
			rd_data <= rd_req ? rd_data_next : rd_data;
			rd_valid_reg <= rd_req;
		end
	end

	a_fault_code: assert property (@(posedge sys_clk) disable iff (!rst_n)
		remote_done && remote_diode_fault |=> remote_reg == `DIODE_FAULT_CODE)
		else $error("remote fault not reported as fault code");

	a_result_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!local_done |=> $stable(local_reg))
		else $error("local result changed without a conversion");

	a_result_write_blocked: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wr_valid && !code_is_offset |=> $stable(offset_reg))
		else $error("offset changed by write to another location");

	a_offset_range: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$signed(offset_reg) <= $signed(`OFFSET_MAX) && $signed(offset_reg) >= $signed(`OFFSET_MIN)
		&& offset_reg[3:0] == 4'h0)
		else $error("offset out of span or finer than a quarter degree");

	a_offset_applied: assert property (@(posedge sys_clk) disable iff (!rst_n)
		local_done && offset_reg == 16'h0000 && local_raw != `DIODE_FAULT_CODE
		|=> local_reg == $past(local_raw))
		else $error("zero offset altered local result");

	sequence s_low_read;
		rd_req && !byte_idx_reg[0] && !cmd_start;
	endsequence

	sequence s_high_read;
		rd_req && byte_idx_reg[0] && !cmd_start;
	endsequence

	// one idle cycle between bytes, as a byte-at-a-time host leaves it
	sequence s_quiet;
		!rd_req && !cmd_start;
	endsequence

	a_high_from_snap: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_high_read |=> rd_data == $past(snap_reg[15:8]))
		else $error("high byte not taken from snapshot");

	a_low_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(s_low_read and code_is_local and byte_idx_reg == 2'h0)
		|=> rd_data == $past(local_reg[7:0]))
		else $error("first byte is not local low byte");

	a_all_remote: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rd_req && all_temps && byte_idx_reg == 2'h2 && !cmd_start
		|=> rd_data == $past(remote_reg[7:0]))
		else $error("third byte of combined read is not remote low");

	a_offset_readback: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(s_low_read and code_is_offset) |=> rd_data == $past(offset_reg[7:0]))
		else $error("offset read-back does not start with low byte");

	a_valid_follows: assert property (@(posedge sys_clk) disable iff (!rst_n)
		rd_req |=> rd_valid)
		else $error("read data valid missing");

	a_remote_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!remote_done |=> $stable(remote_reg))
		else $error("remote result changed without a conversion");

	a_remote_offset: assert property (@(posedge sys_clk) disable iff (!rst_n)
		remote_done && !remote_diode_fault && offset_reg == 16'h0000
		&& remote_raw != `DIODE_FAULT_CODE |=> remote_reg == $past(remote_raw))
		else $error("zero offset altered remote result");

	a_fault_remote_only: assert property (@(posedge sys_clk) disable iff (!rst_n)
		remote_done && !remote_diode_fault |=> remote_reg != `DIODE_FAULT_CODE)
		else $error("fault code shown for a healthy diode");

	a_local_no_fault: assert property (@(posedge sys_clk) disable iff (!rst_n)
		local_done |=> local_reg != `DIODE_FAULT_CODE)
		else $error("fault code shown on local channel");

	// saturation: a sum of two like-signed words keeps their sign
	a_pos_saturates: assert property (@(posedge sys_clk) disable iff (!rst_n)
		local_done && !local_raw[15] && !offset_reg[15] |=> !local_reg[15])
		else $error("positive local sum wrapped negative");

	a_neg_saturates: assert property (@(posedge sys_clk) disable iff (!rst_n)
		local_done && local_raw[15] && offset_reg[15] |=> local_reg[15])
		else $error("negative local sum wrapped positive");

	a_offset_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!wr_valid |=> $stable(offset_reg))
		else $error("offset changed without a write");

	a_low_no_commit: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wr_valid && !wr_half_reg |=> $stable(offset_reg))
		else $error("offset committed on the low byte");

	a_result_no_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
		wr_valid && !remote_done |=> $stable(remote_reg))
		else $error("write altered remote result");

	a_write_ok_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cmd_start && cmd_code == `CMD_TEMP_OFFSET |=> cmd_write_ok)
		else $error("offset command not accepted for writing");

	a_write_ok_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cmd_start && cmd_code != `CMD_TEMP_OFFSET |=> !cmd_write_ok)
		else $error("read-only command accepted for writing");

	a_valid_drops: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!rd_req |=> !rd_valid)
		else $error("read data valid without a request");

	a_data_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!rd_req |=> $stable(rd_data))
		else $error("read data changed without a request");

	a_start_rewinds: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cmd_start |=> byte_idx_reg == 2'h0)
		else $error("new command did not restart at low byte");

	a_single_wrap: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(s_high_read and !all_temps) |=> byte_idx_reg == 2'h0)
		else $error("single channel read did not wrap after two bytes");

	a_combined_wrap: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(s_high_read and all_temps and byte_idx_reg == 2'h3)
		|=> byte_idx_reg == 2'h0)
		else $error("combined read did not wrap after four bytes");

	a_remote_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(s_low_read and code_is_remote) |=> rd_data == $past(remote_reg[7:0]))
		else $error("first byte is not remote low byte");

	a_local_pair: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(s_low_read and code_is_local and byte_idx_reg == 2'h0) ##1 s_quiet ##1 s_high_read
		|=> rd_data == $past(local_reg[15:8], 3))
		else $error("local high byte from another conversion");

	a_remote_pair: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(s_low_read and code_is_remote) ##1 s_quiet ##1 s_high_read
		|=> rd_data == $past(remote_reg[15:8], 3))
		else $error("remote high byte from another conversion");

	a_offset_pair: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(s_low_read and code_is_offset) ##1 s_quiet ##1 s_high_read
		|=> rd_data == $past(offset_reg[15:8], 3))
		else $error("offset read-back high byte mismatched");

	a_all_remote_pair: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(s_low_read and all_temps and byte_idx_reg == 2'h2) ##1 s_quiet ##1 s_high_read
		|=> rd_data == $past(remote_reg[15:8], 3))
		else $error("fourth byte of combined read is not remote high");

	a_reset_clears: assert property (@(posedge sys_clk)
		!rst_n |=> !rd_valid && !cmd_write_ok && offset_reg == `OFFSET_RESET)
		else $error("reset did not clear read and offset state");
endmodule

// ===== dv/host_model.sv
// host controller model driving the serial command port
`timescale 1ns/1ps
module host_model
(
	input wire logic sys_clk,
	input wire logic rd_valid,
	input wire logic [7:0] rd_data,
	output logic cmd_start,
	output logic [7:0] cmd_code,
	output logic [7:0] cmd_read_len,
	output logic wr_valid,
	output logic [7:0] wr_data,
	output logic rd_req
);
	initial
	begin
		{cmd_start, wr_valid, rd_req} = 3'b000;
		{cmd_code, cmd_read_len, wr_data} = 24'h000200;
	end
	// k: 0 start, 1 write byte, 2 read byte; one pulse, then idle
	task automatic op(input int k, input logic [7:0] v, input logic [7:0] n,
		output logic [7:0] q);
		@(posedge sys_clk) #10;
		cmd_start = (k == 0);
		wr_valid = (k == 1);
		rd_req = (k == 2);
		if (k == 0)
			{cmd_code, cmd_read_len} = {v, n};
		wr_data = v;
		@(posedge sys_clk) #10;
		{cmd_start, wr_valid, rd_req} = 3'b000;
		// released data line shows garbage, not the last byte
		wr_data = ~v;
		q = rd_valid ? rd_data : 8'hxx;
	endtask
endmodule

// ===== dv/testbench.sv
// self-checking bench for the temperature readout
`timescale 1ns/1ps
`include "temp_readout_defines.svh"
module testbench import temp_readout_pkg::*;;
	typedef struct {logic [15:0] lr, rr; logic f; logic [15:0] le, re;} row_t;
	logic sys_clk = 1'b0;
	logic rst_n, local_done, remote_done, remote_diode_fault, cmd_start, wr_valid;
	logic rd_req, rd_valid, cmd_write_ok;
	logic [15:0] local_raw, remote_raw;
	logic [7:0] cmd_code, cmd_read_len, wr_data, rd_data, b, lo;
	temp_word_t w;
	int err_total = 0;
	int total_checks = 0;
	int cyc = 0;
	row_t rows [4] = '{'{16'h0040, 16'hffc0, 0, 16'h0040, 16'hffc0},
		'{16'h1f40, 16'he0c0, 0, 16'h1f40, 16'he0c0},
		'{16'hfb3e, 16'h04c2, 1, 16'hfb3e, 16'h8000},
		'{16'h7fff, 16'h8001, 0, 16'h7fff, 16'h8001}};
	temp_readout temp_readout_inst (.*);
	host_model host_model_inst (.*);
	always #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			err_total++;
			conclude();
		end
	end
	task automatic conclude;
		if (err_total == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		total_checks++;
		if (s !== e)
		begin
			err_total++;
			$display("Error %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic st(input logic [7:0] c, input logic [7:0] n);
		host_model_inst.op(0, c, n, b);
	endtask
	task automatic wb(input logic [7:0] v);
		host_model_inst.op(1, v, 8'h00, b);
	endtask
	task automatic rdw(output temp_word_t r);
		host_model_inst.op(2, 8'h00, 8'h00, lo);
		host_model_inst.op(2, 8'h00, 8'h00, b);
		r = {b, lo};
	endtask
	task automatic conv(input logic [15:0] l, input logic [15:0] r, input logic f);
		@(posedge sys_clk) #10;
		{local_done, remote_done, local_raw, remote_raw, remote_diode_fault} = {2'b11, l, r, f};
		@(posedge sys_clk) #10;
		{local_done, remote_done, local_raw, remote_raw} = {2'b00, ~l, ~r};
	endtask
	initial
	begin
		rst_n = 1'b0;
		{local_done, remote_done, local_raw, remote_raw, remote_diode_fault} = 35'h0;
		repeat (2) @(posedge sys_clk);
		#10 rst_n = 1'b1;
		st(`CMD_LOCAL_RESULT, `LEN_ALL_TEMPS);
		rdw(w);
		chk(w, `RESULT_RESET);
		st(`CMD_TEMP_OFFSET, `LEN_SINGLE);
		rdw(w);
		chk(w, `OFFSET_RESET);
		foreach (rows[i])
		begin
			conv(rows[i].lr, rows[i].rr, rows[i].f);
			st(`CMD_LOCAL_RESULT, `LEN_ALL_TEMPS);
			rdw(w);
			chk(w, rows[i].le);
			rdw(w);
			chk(w, rows[i].re);
			st(`CMD_REMOTE_RESULT, `LEN_SINGLE);
			rdw(w);
			chk(w, rows[i].re);
		end
		st(`CMD_REMOTE_RESULT, `LEN_SINGLE);
		chk({15'h0, cmd_write_ok}, 16'h0000);
		wb(8'h55);
		wb(8'h00);
		st(`CMD_REMOTE_RESULT, `LEN_SINGLE);
		rdw(w);
		chk(w, 16'h8001);
		st(`CMD_TEMP_OFFSET, `LEN_SINGLE);
		rdw(w);
		chk(w, `OFFSET_RESET);
		st(`CMD_TEMP_OFFSET, `LEN_SINGLE);
		chk({15'h0, cmd_write_ok}, 16'h0001);
		wb(8'h48);
		wb(8'h00);
		st(`CMD_TEMP_OFFSET, `LEN_SINGLE);
		rdw(w);
		chk(w, 16'h0040);
		conv(16'h0040, 16'h0100, 1'b0);
		st(`CMD_LOCAL_RESULT, `LEN_ALL_TEMPS);
		rdw(w);
		chk(w, 16'h0080);
		rdw(w);
		chk(w, 16'h0140);
		st(`CMD_TEMP_OFFSET, `LEN_SINGLE);
		wb(8'h00);
		wb(8'h30);
		st(`CMD_TEMP_OFFSET, `LEN_SINGLE);
		rdw(w);
		chk(w, `OFFSET_MAX);
		conv(16'h7f00, 16'h0000, 1'b0);
		// new conversion lands between the two bytes of one read
		st(`CMD_LOCAL_RESULT, `LEN_SINGLE);
		host_model_inst.op(2, 8'h00, 8'h00, lo);
		conv(16'h0000, 16'h0000, 1'b0);
		host_model_inst.op(2, 8'h00, 8'h00, b);
		chk({b, lo}, `TEMP_MAX);
		rdw(w);
		chk(w, 16'h2000);
		// out-of-span negative offset clamps, then drives both sums negative
		st(`CMD_TEMP_OFFSET, `LEN_SINGLE);
		wb(8'h00);
		wb(8'h80);
		st(`CMD_TEMP_OFFSET, `LEN_SINGLE);
		rdw(w);
		chk(w, `OFFSET_MIN);
		conv(16'hfb3e, 16'h8001, 1'b0);
		st(`CMD_LOCAL_RESULT, `LEN_ALL_TEMPS);
		rdw(w);
		chk(w, 16'hdb3e);
		rdw(w);
		chk(w, 16'h8001);
		// mid-run reset must drop the stored offset
		@(posedge sys_clk) #10;
		rst_n = 1'b0;
		repeat (2) @(posedge sys_clk);
		#10 rst_n = 1'b1;
		st(`CMD_TEMP_OFFSET, `LEN_SINGLE);
		rdw(w);
		chk(w, `OFFSET_RESET);
		conclude();
	end
endmodule
